/* File: eprom_prog_ctrl.sv */
// eprom_prog_ctrl.sv: host-side controller driving an array of 32k x 8 EPROMs by their pins
// assumes shared address, oe, supply and data pins, one ce per device; one command at a time
`timescale 1ns/1ps
`include "eprom_prog_cfg.svh"

module eprom_prog_ctrl
    import eprom_prog_pkg::*;
#(
    parameter int NDEV = 4,
    parameter int AW = 15,
    parameter int PULSE_CYC = `PROG_PULSE_CYC,
    parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hA5  // arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire cmd_t i_cmd,
    input wire logic i_use_ptr,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [NDEV-1:0] i_dev_sel,
    input wire logic i_supply_dip,
    output logic o_cmd_ready,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_fail,
    output logic [4:0] o_pulses,
    output logic [AW-1:0] o_ptr,
    output logic o_id_match,
    output logic [AW-1:0] o_addr,
    output logic [NDEV-1:0] o_ce_n,
    output logic o_oe_n,
    output logic o_vpp_high,
    output logic o_id_high_volt,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_oe
);
    localparam int TW = 17;
    localparam logic [TW-1:0] LD_PULSE = TW'(PULSE_CYC - 1);
    localparam logic [TW-1:0] LD_SETUP = TW'(`PROG_SETUP_CYC - 1);
    localparam logic [TW-1:0] LD_HOLD = TW'(`PROG_HOLD_CYC - 1);
    localparam logic [TW-1:0] LD_READ = TW'(`READ_WAIT_CYC - 1);
    localparam logic [4:0] PULSE_LIMIT = 5'(`MAX_PULSES);

    state_t state_ff, nxt_state;
    logic [AW-1:0] addr_ff, nxt_addr, tgt_ff, nxt_tgt, ptr_ff, nxt_ptr;
    logic [NDEV-1:0] ce_n_ff, nxt_ce_n, sel_ff, nxt_sel;
    logic oe_n_ff, nxt_oe_n, vpp_ff, nxt_vpp, idhv_ff, nxt_idhv;
    logic [7:0] dq_ff, nxt_dq, rdata_ff, nxt_rdata, maker_ff, nxt_maker;
    logic dq_oe_ff, nxt_dq_oe, done_ff, nxt_done, fail_ff, nxt_fail;
    logic idx_ff, nxt_idx, dip_seen_ff, nxt_dip_seen, idm_ff, nxt_idm;
    logic [4:0] pulses_ff, nxt_pulses;
    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_exp;
    // three-stage synchronisers; stage 1 feeds stage 2 only
    logic [8:0] sy1_ff, sy2_ff, sy3_ff, stab_ff, nxt_stab;

    wait_timer #(.W(TW)) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_expired(tmr_exp)
    );

    // a pin change is accepted once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < 9; i++)
            nxt_stab[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] : stab_ff[i];
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            sy1_ff <= 9'h000;
            sy2_ff <= 9'h000;
            sy3_ff <= 9'h000;
            stab_ff <= 9'h000;
        end
        else
        begin
            sy1_ff <= {i_supply_dip, i_dq};
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            stab_ff <= nxt_stab;
        end
    end

    // sequencer: one command runs to completion before the next is taken
    always_comb
    begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_tgt = tgt_ff;
        nxt_ptr = ptr_ff;
        nxt_ce_n = ce_n_ff;
        nxt_sel = sel_ff;
        nxt_oe_n = oe_n_ff;
        nxt_vpp = vpp_ff;
        nxt_idhv = idhv_ff;
        nxt_dq = dq_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_rdata = rdata_ff;
        nxt_maker = maker_ff;
        nxt_done = 1'b0;
        nxt_fail = fail_ff;
        nxt_idx = idx_ff;
        nxt_idm = idm_ff;
        nxt_pulses = pulses_ff;
        nxt_dip_seen = dip_seen_ff | stab_ff[8];  // set wins over the clear below
        tmr_load = 1'b0;
        tmr_count = LD_READ;
        case (state_ff)
            S_IDLE:
            begin
                nxt_ce_n = '1;
                nxt_oe_n = 1'b1;
                nxt_dq_oe = 1'b0;
                nxt_vpp = 1'b0;
                nxt_idhv = 1'b0;
                if (i_cmd_valid)
                begin
                    nxt_tgt = i_use_ptr ? ptr_ff : i_addr;
                    nxt_sel = i_dev_sel;
                    tmr_load = 1'b1;
                    if (i_cmd == CMD_READ)
                    begin
                        nxt_ce_n = ~i_dev_sel;
                        nxt_oe_n = 1'b0;
                        if (dip_seen_ff)
                        begin
                            // park on a different address first
                            nxt_addr = nxt_tgt ^ AW'(1);
                            nxt_dip_seen = stab_ff[8];
                            nxt_state = S_RD_SKEW;
                        end
                        else
                        begin
                            nxt_addr = nxt_tgt;
                            nxt_state = S_RD_WAIT;
                        end
                    end
                    else if (i_cmd == CMD_PROG)
                    begin
                        nxt_addr = nxt_tgt;
                        nxt_dq = i_wdata;
                        nxt_dq_oe = 1'b1;
                        nxt_vpp = 1'b1;
                        nxt_pulses = 5'h00;
                        nxt_fail = 1'b0;
                        tmr_count = LD_SETUP;
                        nxt_state = S_PG_SETUP;
                    end
                    else
                    begin
                        nxt_addr = '0;
                        nxt_idhv = 1'b1;
                        nxt_ce_n = '0;
                        nxt_oe_n = 1'b0;
                        nxt_idx = 1'b0;
                        nxt_state = S_ID_WAIT;
                    end
                end
            end
            S_RD_SKEW:
                if (tmr_exp)
                begin
                    nxt_addr = tgt_ff;
                    tmr_load = 1'b1;
                    nxt_state = S_RD_WAIT;
                end
            S_RD_WAIT:
                if (tmr_exp)
                begin
                    nxt_rdata = stab_ff[7:0];
                    nxt_done = 1'b1;
                    nxt_state = S_IDLE;
                end
            S_ID_WAIT:
                if (tmr_exp)
                begin
                    if (!idx_ff)
                    begin
                        nxt_maker = stab_ff[7:0];
                        nxt_idx = 1'b1;
                        nxt_addr = AW'(1) << `ID_SELECT_BIT;
                        tmr_load = 1'b1;
                    end
                    else
                    begin
                        nxt_rdata = stab_ff[7:0];
                        nxt_idm = (maker_ff == MAKER_CODE) && (stab_ff[7:0] == DEVICE_CODE);
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end
            S_PG_SETUP:
                if (tmr_exp)
                begin
                    nxt_ce_n = ~sel_ff;
                    nxt_pulses = pulses_ff + 5'h01;
                    tmr_load = 1'b1;
                    tmr_count = LD_PULSE;
                    nxt_state = S_PG_PULSE;
                end
            S_PG_PULSE:
                if (tmr_exp)
                begin
                    nxt_ce_n = '1;
                    tmr_load = 1'b1;
                    tmr_count = LD_HOLD;
                    nxt_state = S_PG_HOLD;
                end
            S_PG_HOLD:
                if (tmr_exp)
                begin
                    nxt_dq_oe = 1'b0;
                    nxt_oe_n = 1'b0;
                    tmr_load = 1'b1;
                    nxt_state = S_PG_VERIFY;
                end
            S_PG_VERIFY:
                if (tmr_exp)
                begin
                    nxt_rdata = stab_ff[7:0];
                    nxt_oe_n = 1'b1;
                    if (stab_ff[7:0] == dq_ff)
                    begin
                        nxt_ptr = tgt_ff + AW'(1);
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                    else if (pulses_ff >= PULSE_LIMIT)
                    begin
                        nxt_fail = 1'b1;
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end
                    else
                    begin
                        nxt_dq_oe = 1'b1;
                        tmr_load = 1'b1;
                        tmr_count = LD_SETUP;
                        nxt_state = S_PG_SETUP;
                    end
                end
            default:
                nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_ff <= S_IDLE;
            addr_ff <= '0;
            tgt_ff <= '0;
            ptr_ff <= '0;
            ce_n_ff <= '1;
            sel_ff <= '0;
            oe_n_ff <= 1'b1;
            vpp_ff <= 1'b0;
            idhv_ff <= 1'b0;
            dq_ff <= `ERASED_BYTE;
            dq_oe_ff <= 1'b0;
            rdata_ff <= 8'h00;
            maker_ff <= 8'h00;
            done_ff <= 1'b0;
            fail_ff <= 1'b0;
            idx_ff <= 1'b0;
            idm_ff <= 1'b0;
            pulses_ff <= 5'h00;
            dip_seen_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            tgt_ff <= nxt_tgt;
            ptr_ff <= nxt_ptr;
            ce_n_ff <= nxt_ce_n;
            sel_ff <= nxt_sel;
            oe_n_ff <= nxt_oe_n;
            vpp_ff <= nxt_vpp;
            idhv_ff <= nxt_idhv;
            dq_ff <= nxt_dq;
            dq_oe_ff <= nxt_dq_oe;
            rdata_ff <= nxt_rdata;
            maker_ff <= nxt_maker;
            done_ff <= nxt_done;
            fail_ff <= nxt_fail;
            idx_ff <= nxt_idx;
            idm_ff <= nxt_idm;
            pulses_ff <= nxt_pulses;
            dip_seen_ff <= nxt_dip_seen;
        end
    end

    // pins and status straight from flops, except ready, which decodes state_ff
    assign o_cmd_ready = (state_ff == S_IDLE);
    assign o_done = done_ff;
    assign o_rdata = rdata_ff;
    assign o_fail = fail_ff;
    assign o_pulses = pulses_ff;
    assign o_ptr = ptr_ff;
    assign o_id_match = idm_ff;
    assign o_addr = addr_ff;
    assign o_ce_n = ce_n_ff;
    assign o_oe_n = oe_n_ff;
    assign o_vpp_high = vpp_ff;
    assign o_id_high_volt = idhv_ff;
    assign o_dq = dq_ff;
    assign o_dq_oe = dq_oe_ff;

    // helper: length of the current ce low stretch while the program supply is high
    logic [TW-1:0] ce_low_cnt_ff;
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            ce_low_cnt_ff <= '0;
        else
            ce_low_cnt_ff <= (vpp_ff && ~&ce_n_ff) ? ce_low_cnt_ff + 1'b1 : '0;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    a_no_static_ce: assert property (ce_low_cnt_ff <= TW'(PULSE_CYC))
        else $error("program ce held low past one pulse");
    a_pulse_length: assert property ($rose(vpp_ff && ~&ce_n_ff) |=> (vpp_ff && ~&ce_n_ff) [*8])
        else $error("program pulse cut short");
    a_pulse_limit: assert property (pulses_ff <= PULSE_LIMIT)
        else $error("more than the pulse limit applied");
    a_prog_oe_high: assert property ((vpp_ff && ~&ce_n_ff) |-> oe_n_ff && dq_oe_ff)
        else $error("program pulse without oe high and data driven");
    a_no_contention: assert property (dq_oe_ff |-> oe_n_ff)
        else $error("host drives data while oe low");
    a_verify_mode: assert property ((state_ff == S_PG_VERIFY) |-> &ce_n_ff && !oe_n_ff && vpp_ff)
        else $error("verify mode pins wrong");
    a_dev_inhibit: assert property ((state_ff == S_PG_PULSE) |-> (~ce_n_ff == sel_ff))
        else $error("unselected device pulsed");
    a_id_pins: assert property (idhv_ff |-> ce_n_ff == '0 && !oe_n_ff && !vpp_ff
                                && addr_ff[AW-1:1] == '0)
        else $error("identification pins not held low");
    a_id_select: assert property (idhv_ff |-> addr_ff[`ID_SELECT_BIT] == idx_ff)
        else $error("id select line mismatch");
    a_fail_at_limit: assert property ($rose(fail_ff) |-> pulses_ff == PULSE_LIMIT && done_ff)
        else $error("failure flagged before the pulse limit");
    a_advance: assert property (done_ff && $past(state_ff) == S_PG_VERIFY && !fail_ff
                                |-> ptr_ff == tgt_ff + AW'(1))
        else $error("pointer not advanced after verify");
    a_dip_skew: assert property ((state_ff == S_RD_SKEW) |-> addr_ff != tgt_ff)
        else $error("no address transition after supply dip");

    c_read: cover property (done_ff && $past(state_ff) == S_RD_WAIT);
    c_prog_ok: cover property (done_ff && $past(state_ff) == S_PG_VERIFY && !fail_ff);
    c_prog_fail: cover property ($rose(fail_ff));
    c_ident: cover property ($rose(idm_ff));
endmodule // eprom_prog_ctrl

/* File: eprom_prog_cfg.svh */
// eprom_prog_cfg.svh: timing counts, pin field positions and limits for the EPROM programmer
// assumes a 200 MHz system clock; times are in ns
`ifndef EPROM_PROG_CFG_SVH
`define EPROM_PROG_CFG_SVH

`define CLK_PERIOD_NS 5
// program pulse width, nominal
`define T_PROG_PULSE_NS 100000
// address, data and program supply setup before the pulse (least)
`define T_PROG_SETUP_NS 1000
// data hold after the pulse (least)
`define T_PROG_HOLD_NS 1000
// address_access_delay, slowest grade (least wait for the host)
`define T_ADDR_ACCESS_NS 200
// least cycles, rounded up
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_PULSE_CYC (`T_PROG_PULSE_NS / `CLK_PERIOD_NS)
`define PROG_SETUP_CYC `CYC_UP(`T_PROG_SETUP_NS)
`define PROG_HOLD_CYC `CYC_UP(`T_PROG_HOLD_NS)
// access wait, three synchroniser stages, the agree stage and one edge so the first stage never races the pins
`define SYNC_STAGES 3
`define READ_WAIT_CYC (`CYC_UP(`T_ADDR_ACCESS_NS) + `SYNC_STAGES + 2)
// fast algorithm pulse limit
`define MAX_PULSES 25
// address pin positions
`define ID_ENTRY_BIT 9
`define ID_SELECT_BIT 0
// erased byte value
`define ERASED_BYTE 8'hFF

`endif

/* File: eprom_prog_pkg.sv */
// eprom_prog_pkg.sv: types shared by the EPROM programmer
// no assumptions beyond the cfg header
package eprom_prog_pkg;

    typedef enum logic [1:0]
    {
        CMD_READ = 2'h0,
        CMD_PROG = 2'h1,
        CMD_IDENT = 2'h2
    } cmd_t;

    typedef enum logic [7:0]
    {
        S_IDLE = 8'h01,
        S_RD_SKEW = 8'h02,
        S_RD_WAIT = 8'h04,
        S_ID_WAIT = 8'h08,
        S_PG_SETUP = 8'h10,
        S_PG_PULSE = 8'h20,
        S_PG_HOLD = 8'h40,
        S_PG_VERIFY = 8'h80
    } state_t;

endpackage

/* File: wait_timer.sv */
// wait_timer.sv: down counter for the programmer's timed phases
// assumes i_count is only sampled on i_load
`timescale 1ns/1ps
module wait_timer #(
    parameter int W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    output logic o_expired
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // load wins; otherwise count down and stop at zero
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (i_load)
            nxt_cnt = i_count;
        else if (cnt_ff != '0)
            nxt_cnt = cnt_ff - 1'b1;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    // decode of the count flop only; callers reload on expiry, so reading i_load here would close a loop
    assign o_expired = (cnt_ff == '0);
endmodule // wait_timer

/* File: eprom_dev_model.sv */
// eprom_dev_model.sv: behavioural array of 32k x 8 EPROMs seen from their pins
// assumes shared address, gate, supply and data pins with one select per device
`timescale 1ns/1ps
module eprom_dev_model #(
    parameter int NDEV = 4,
    parameter int AW = 15,
    parameter int ACC_NS = 200,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hA5 // arbitrary value
) (
    input wire logic [AW-1:0] i_addr,
    input wire logic [NDEV-1:0] i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_vpp_high,
    input wire logic i_id_high_volt,
    input wire logic i_supply_dip,
    input wire logic [7:0] i_dq,
    input wire logic [5:0] i_need,
    output logic [7:0] o_dq
);
    logic [7:0] mem [NDEV][2**AW];
    int hits [NDEV];
    realtime t_chg;
    logic [7:0] val;
    logic any;
    logic dip_stale;

    // fresh parts come out erased
    initial
    begin
        foreach (mem[d, a]) mem[d][a] = 8'hFF;
        foreach (hits[d]) hits[d] = 0;
        t_chg = 0.0;
        o_dq = 8'h00;
        dip_stale = 1'b0;
    end

    // stubborn cells: a byte takes i_need pulses before its zeros stick
    for (genvar d = 0; d < NDEV; d++)
    begin : g_dev
        always @(posedge i_ce_n[d])
        begin
            if (i_vpp_high && i_oe_n)
            begin
                hits[d] = hits[d] + 1;
                if (hits[d] >= int'(i_need))
                begin
                    mem[d][i_addr] = mem[d][i_addr] & i_dq;
                    hits[d] = 0;
                end
            end
        end
    end

    always @(negedge i_vpp_high) foreach (hits[d]) hits[d] = 0;
    always @(posedge i_supply_dip) dip_stale = 1'b1;
    always @(i_addr) dip_stale = 1'b0;
    always @(i_addr or i_ce_n or i_oe_n or i_id_high_volt or i_vpp_high) t_chg = $realtime;

    // several drivers approximated as wired-and; unsettled or idle pins toggle, never hold stale data
    always #1
    begin
        any = 1'b0;
        val = 8'hFF;
        for (int d = 0; d < NDEV; d++)
        begin
            if (!i_oe_n && (!i_ce_n[d] || i_vpp_high))
            begin
                any = 1'b1;
                val = val & (i_id_high_volt ? (i_addr[0] ? DEVICE_CODE : MAKER_CODE) : mem[d][i_addr]);
            end
        end
        if (any && !dip_stale && ($realtime - t_chg >= ACC_NS))
            o_dq = val;
        else
            o_dq = ~o_dq;
    end
endmodule // eprom_dev_model

/* File: testbench.sv */
// testbench.sv: self-checking bench driving the EPROM programmer against the device model
// assumes a shortened program pulse; the design carries its own assertions
`timescale 1ns/1ps
`include "eprom_prog_cfg.svh"
module testbench
    import eprom_prog_pkg::*;
;
    localparam int PULSE = 20;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] DEVICE = 8'hC6; // arbitrary value

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd = CMD_READ;
    logic use_ptr = 1'b0;
    logic [14:0] addr = 15'h0000;
    logic [7:0] wdata = 8'h00;
    logic [3:0] dev_sel = 4'h0;
    logic supply_dip = 1'b0;
    logic [5:0] need = 6'h01;
    logic cmd_ready, done, fail, id_match, oe_n, vpp_high, id_high_volt, dq_oe;
    logic [7:0] rdata, dq_out, mdl_dq;
    logic [4:0] pulses;
    logic [14:0] ptr, pin_addr;
    logic [3:0] ce_n, ce_mask;
    wire logic [7:0] dq_bus;
    int n_fail = 0;
    int total_checks = 0;
    int lo_run, max_lo;
    logic saw_flip, saw_vpp, saw_idv;

    // controller owns the data pins while its drivers are on
    assign dq_bus = dq_oe ? dq_out : mdl_dq;
    always #2.5 clk_sys = ~clk_sys;

    eprom_prog_ctrl #(.NDEV(4), .AW(15), .PULSE_CYC(PULSE), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    eprom_prog_ctrl_i (.i_clk_sys(clk_sys), .i_reset(reset), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_use_ptr(use_ptr), .i_addr(addr), .i_wdata(wdata), .i_dev_sel(dev_sel), .i_supply_dip(supply_dip),
        .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(rdata), .o_fail(fail), .o_pulses(pulses),
        .o_ptr(ptr), .o_id_match(id_match), .o_addr(pin_addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
        .o_vpp_high(vpp_high), .o_id_high_volt(id_high_volt), .i_dq(dq_bus), .o_dq(dq_out), .o_dq_oe(dq_oe));

    // slowest grade part, so the read wait has no slack to hide behind
    eprom_dev_model #(.NDEV(4), .AW(15), .ACC_NS(`T_ADDR_ACCESS_NS), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    eprom_dev_model_i (.i_addr(pin_addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_vpp_high(vpp_high),
        .i_id_high_volt(id_high_volt), .i_supply_dip(supply_dip), .i_dq(dq_bus), .i_need(need), .o_dq(mdl_dq));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one command, request held until taken; pins watched until done
    task automatic run_cmd(input cmd_t c, input logic [14:0] a, input logic [7:0] d, input logic [3:0] sel,
                           input logic up);
        int n;
        n = 0;
        lo_run = 0;
        max_lo = 0;
        ce_mask = 4'h0;
        saw_flip = 1'b0;
        saw_vpp = 1'b0;
        saw_idv = 1'b0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= c;
        addr <= a;
        wdata <= d;
        dev_sel <= sel;
        use_ptr <= up;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (cmd_ready !== 1'b1)
        begin
            check(cmd_ready, 1'b1);
            finish_test();
        end
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
            ce_mask |= ~ce_n;
            lo_run = (ce_n !== 4'hF) ? lo_run + 1 : 0;
            max_lo = (lo_run > max_lo) ? lo_run : max_lo;
            saw_vpp |= vpp_high;
            saw_idv |= id_high_volt;
            saw_flip |= (pin_addr === (a ^ 15'h0001));
        end
        while (done !== 1'b1 && n < 15000);
        if (done !== 1'b1)
        begin
            check(done, 1'b1);
            finish_test();
        end
        @(negedge clk_sys);
        check({ce_n, oe_n, vpp_high, dq_oe}, {4'hF, 1'b1, 1'b0, 1'b0});
    endtask

    task automatic read_chk(input logic [14:0] a, input logic [3:0] sel, input logic [7:0] exp);
        run_cmd(CMD_READ, a, 8'h00, sel, 1'b0);
        check(rdata, exp);
        check(ce_mask, sel);
    endtask

    task automatic prog_chk(input logic [14:0] a, input logic [7:0] d, input logic [3:0] sel, input logic up,
                            input logic [5:0] nd, input logic [4:0] ep, input logic ef);
        need <= nd;
        run_cmd(CMD_PROG, a, d, sel, up);
        check(pulses, ep);
        check(fail, ef);
        check(max_lo, PULSE);
        check(ce_mask, sel);
        check(saw_vpp, 1'b1);
    endtask

    task automatic t_program();
        prog_chk(15'h0123, 8'h3C, 4'h1, 1'b0, 6'h01, 5'h01, 1'b0);
        check(ptr, 15'h0124);
        read_chk(15'h0123, 4'h1, 8'h3C);
        read_chk(15'h0123, 4'h2, 8'hFF);
        prog_chk(15'h0200, 8'h00, 4'h4, 1'b0, 6'h03, 5'h03, 1'b0);
        read_chk(15'h0200, 4'h4, 8'h00);
        $display("test program and retry done");
    endtask

    task automatic t_parallel();
        prog_chk(15'h7FFF, 8'hA6, 4'hF, 1'b0, 6'h01, 5'h01, 1'b0);
        check(ptr, 15'h0000);
        for (int d = 0; d < 4; d++)
            read_chk(15'h7FFF, 4'h1 << d, 8'hA6);
        $display("test parallel done");
    endtask

    // zeros cannot return to ones, so this byte never verifies
    task automatic t_limit();
        prog_chk(15'h0123, 8'hF0, 4'h1, 1'b0, 6'h01, 5'(`MAX_PULSES), 1'b1);
        check(ptr, 15'h0000);
        read_chk(15'h0123, 4'h1, 8'h30);
        prog_chk(15'h0555, 8'h11, 4'h1, 1'b1, 6'h01, 5'h01, 1'b0);
        check(ptr, 15'h0001);
        read_chk(15'h0000, 4'h1, 8'h11);
        $display("test limit and pointer done");
    endtask

    task automatic t_ident();
        run_cmd(CMD_IDENT, 15'h7FFF, 8'h00, 4'h0, 1'b0);
        check(rdata, DEVICE);
        check(id_match, 1'b1);
        check(saw_idv, 1'b1);
        check(ce_mask, 4'hF);
        $display("test ident done");
    endtask

    // same address read before and after the dip; only a transition clears stale output
    task automatic t_dip();
        read_chk(15'h0200, 4'h4, 8'h00);
        @(posedge clk_sys);
        supply_dip <= 1'b1;
        repeat (4) @(posedge clk_sys);
        supply_dip <= 1'b0;
        read_chk(15'h0200, 4'h4, 8'h00);
        check(saw_flip, 1'b1);
        $display("test supply dip done");
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check({cmd_ready, ce_n, oe_n, vpp_high, id_high_volt, dq_oe}, {1'b1, 4'hF, 1'b1, 3'h0});
        $display("test reset done");
        t_program();
        t_parallel();
        t_limit();
        t_ident();
        t_dip();
        finish_test();
    end
endmodule // testbench
